// file: inc/sfdpbp_pkg.sv
/*
 Package for the basic parameter table ROM slice, relative bytes 0Ch to 1Bh.
 Holds the byte addresses, field positions and constant contents of the slice.
 Assumes nothing of its surroundings beyond a byte-wide read path.
*/
package sfdpbp_pkg;

   // ==========================================================
   // Address range and organisation of the slice
   localparam logic [7:0] SFDPBP_FIRST_ADDR  = 8'h0C;
   localparam logic [7:0] SFDPBP_LAST_ADDR   = 8'h1B;
   localparam logic [5:0] SFDPBP_FIRST_DWORD = SFDPBP_FIRST_ADDR[7:2];
   localparam int         SFDPBP_DWORDS      = 4;
   localparam int         SFDPBP_LANES       = 4;
   localparam logic [7:0] SFDPBP_ADDR_STEP   = 8'h01;
   localparam logic [7:0] SFDPBP_FILL        = 8'hFF;

   // ==========================================================
   // Reset values
   localparam logic [7:0] SFDPBP_ADDR_RST     = 8'h00;
   localparam logic [7:0] SFDPBP_RDATA_RST    = 8'h00;
   localparam logic       SFDPBP_IN_RANGE_RST = 1'b0;

   // ==========================================================
   // Field positions within a mode/dummy byte
   localparam int SFDPBP_MODE_LSB  = 5;
   localparam int SFDPBP_MODE_W    = 3;
   localparam int SFDPBP_DUMMY_LSB = 0;
   localparam int SFDPBP_DUMMY_W   = 5;

   // ==========================================================
   // Field values
   localparam logic [2:0] SFDPBP_DUAL_OUT_MODE   = 3'h0;
   localparam logic [4:0] SFDPBP_DUAL_OUT_DUMMY  = 5'h08;
   localparam logic [7:0] SFDPBP_DUAL_OUT_OPCODE = 8'h3B;
   localparam logic [2:0] SFDPBP_DUAL_IO_MODE    = 3'h4;
   localparam logic [4:0] SFDPBP_DUAL_IO_DUMMY   = 5'h08;
   localparam logic [7:0] SFDPBP_DUAL_IO_OPCODE  = 8'hBB;
   localparam int         SFDPBP_QPI_BIT         = 4;
   localparam int         SFDPBP_DUAL_ALL_BIT    = 0;
   localparam logic       SFDPBP_QPI_SUPPORTED      = 1'b1;
   localparam logic       SFDPBP_DUAL_ALL_SUPPORTED = 1'b0;
   localparam logic [2:0] SFDPBP_DUAL_ALL_MODE   = 3'h7;
   localparam logic [4:0] SFDPBP_DUAL_ALL_DUMMY  = 5'h1F;
   localparam logic [7:0] SFDPBP_DUAL_ALL_OPCODE = 8'hFF;
   localparam logic [2:0] SFDPBP_QPI_MODE        = 3'h2;
   localparam logic [4:0] SFDPBP_QPI_DUMMY       = 5'h08;
   localparam logic [7:0] SFDPBP_QUAD_IO_OPCODE  = 8'hEB;

endpackage

// file: core/sfdpbp_rom.sv
/*
 Read-only slice of the basic parameter table, relative bytes 0Ch to 1Bh.
 The slice is held as four constant double words behind a byte read port,
 each double word handed out least significant byte first.
 Assumes the command decoder presents a start address with a load strobe,
 then one read strobe per byte wanted; consecutive strobes walk ascending
 addresses from the loaded start. All inputs but NRST are synchronous to CLK.
 NRST is asynchronous and active low; the contents themselves need no reset.
*/
// Behaviour
// - 0Ch reads 08h, 0Dh reads 3Bh
// - 0Eh reads 88h, 0Fh reads BBh
// - 10h reads FEh, four-wire mode supported
// - 10h bit 0 clear: all-dual unsupported
// - Reserved bytes read FFh
// - All-dual entries 16h, 17h read FFh
// - 1Ah reads 48h for four-wire read
// - 1Bh reads EBh opcode
// - Quad I/O opcode equals EBh
`timescale 1ns/1ps
module sfdpbp_rom
   import sfdpbp_pkg::*;
(
   input  wire logic       CLK,
   input  wire logic       NRST,
   input  wire logic       LOAD,
   input  wire logic [7:0] START_ADDR,
   input  wire logic       READ,
   output logic      [7:0] RDATA,
   output logic            IN_RANGE
);

   // ==========================================================
   // Declarations
   logic [7:0]  addr;
   logic [7:0]  next_addr;
   logic        accept;

   logic        addr_at_or_above;
   logic        addr_at_or_below;
   logic        addr_in_range;
   logic [5:0]  dword_idx;
   logic [5:0]  dword_off;
   logic [1:0]  lane;

   logic [7:0]  dual_out_cyc;
   logic [7:0]  dual_io_cyc;
   logic [7:0]  dual_all_cyc;
   logic [7:0]  qpi_cyc;
   logic [7:0]  support_byte;

   logic [31:0] dword_tbl [SFDPBP_DWORDS];
   logic [31:0] cur_dword;
   logic [7:0]  lane_byte [SFDPBP_LANES];
   logic [7:0]  rom_byte;
   logic        next_in_range;

   // ==========================================================
   // Mode and dummy cycle bytes
   always_comb begin
      dual_out_cyc = SFDPBP_FILL;
      dual_out_cyc[SFDPBP_MODE_LSB +: SFDPBP_MODE_W] = SFDPBP_DUAL_OUT_MODE;
      dual_out_cyc[SFDPBP_DUMMY_LSB +: SFDPBP_DUMMY_W] = SFDPBP_DUAL_OUT_DUMMY;
   end

   always_comb begin
      dual_io_cyc = SFDPBP_FILL;
      dual_io_cyc[SFDPBP_MODE_LSB +: SFDPBP_MODE_W] = SFDPBP_DUAL_IO_MODE;
      dual_io_cyc[SFDPBP_DUMMY_LSB +: SFDPBP_DUMMY_W] = SFDPBP_DUAL_IO_DUMMY;
   end

   always_comb begin
      dual_all_cyc = SFDPBP_FILL;
      dual_all_cyc[SFDPBP_MODE_LSB +: SFDPBP_MODE_W] = SFDPBP_DUAL_ALL_MODE;
      dual_all_cyc[SFDPBP_DUMMY_LSB +: SFDPBP_DUMMY_W] = SFDPBP_DUAL_ALL_DUMMY;
   end

   always_comb begin
      qpi_cyc = SFDPBP_FILL;
      qpi_cyc[SFDPBP_MODE_LSB +: SFDPBP_MODE_W] = SFDPBP_QPI_MODE;
      qpi_cyc[SFDPBP_DUMMY_LSB +: SFDPBP_DUMMY_W] = SFDPBP_QPI_DUMMY;
   end

   // ==========================================================
   // Capability byte: four-wire flag, all-dual flag, reserved ones
   for (genvar b = 0; b < 8; b++) begin : g_support
      if (b == SFDPBP_QPI_BIT) begin : g_qpi
         assign support_byte[b] = SFDPBP_QPI_SUPPORTED;
      end else if (b == SFDPBP_DUAL_ALL_BIT) begin : g_dual_all
         assign support_byte[b] = SFDPBP_DUAL_ALL_SUPPORTED;
      end else begin : g_reserved
         assign support_byte[b] = SFDPBP_FILL[b];
      end
   end

   // ==========================================================
   // Double word table, lane 0 in the low byte
   // Dual read settings
   assign dword_tbl[0] = {
      SFDPBP_DUAL_IO_OPCODE,
      dual_io_cyc,
      SFDPBP_DUAL_OUT_OPCODE,
      dual_out_cyc
   };

   // Capabilities and reserved bytes
   assign dword_tbl[1] = {
      SFDPBP_FILL,
      SFDPBP_FILL,
      SFDPBP_FILL,
      support_byte
   };

   // Unsupported all-dual entries
   assign dword_tbl[2] = {
      SFDPBP_DUAL_ALL_OPCODE,
      dual_all_cyc,
      SFDPBP_FILL,
      SFDPBP_FILL
   };

   // Four-wire fast read settings
   assign dword_tbl[3] = {
      SFDPBP_QUAD_IO_OPCODE,
      qpi_cyc,
      SFDPBP_FILL,
      SFDPBP_FILL
   };

   // ==========================================================
   // Address decode
   assign accept           = READ && !LOAD;
   assign addr_at_or_above = (addr >= SFDPBP_FIRST_ADDR);
   assign addr_at_or_below = (addr <= SFDPBP_LAST_ADDR);
   assign addr_in_range    = addr_at_or_above && addr_at_or_below;
   assign dword_idx        = addr[7:2];
   assign dword_off        = dword_idx - SFDPBP_FIRST_DWORD;
   assign lane             = addr[1:0];

   // ==========================================================
   // Byte selection; anything outside the slice reads as ones
   always_comb begin
      cur_dword = {SFDPBP_LANES{SFDPBP_FILL}};
      if (addr_in_range) begin
         unique case (dword_off[1:0])
            2'h0: begin
               cur_dword = dword_tbl[0];
            end
            2'h1: begin
               cur_dword = dword_tbl[1];
            end
            2'h2: begin
               cur_dword = dword_tbl[2];
            end
            2'h3: begin
               cur_dword = dword_tbl[3];
            end
         endcase
      end
   end

   for (genvar n = 0; n < SFDPBP_LANES; n++) begin : g_lane
      assign lane_byte[n] = cur_dword[8*n +: 8];
   end

   always_comb begin
      unique case (lane)
         2'h0: begin
            rom_byte = lane_byte[0];
         end
         2'h1: begin
            rom_byte = lane_byte[1];
         end
         2'h2: begin
            rom_byte = lane_byte[2];
         end
         2'h3: begin
            rom_byte = lane_byte[3];
         end
      endcase
   end

   // ==========================================================
   // Address pointer, ascending walk
   always_comb begin
      next_addr = addr;
      if (LOAD) begin
         next_addr = START_ADDR;
      end else if (READ) begin
         next_addr = addr + SFDPBP_ADDR_STEP;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         addr <= SFDPBP_ADDR_RST;
      end else begin
         addr <= next_addr;
      end
   end

   // ==========================================================
   // Registered read data, held until the next accepted read
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         RDATA <= SFDPBP_RDATA_RST;
      end else if (accept) begin
         RDATA <= rom_byte;
      end
   end

   // ==========================================================
   // Range flag for the byte last read
   assign next_in_range = accept ? addr_in_range : IN_RANGE;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         IN_RANGE <= SFDPBP_IN_RANGE_RST;
      end else begin
         IN_RANGE <= next_in_range;
      end
   end

endmodule

// file: verification/sfdpbp_chk.sv
/* Port checker for the ROM slice.
   Assumes binding onto sfdpbp_rom. */
`timescale 1ns/1ps
module sfdpbp_chk(input wire logic CLK, NRST, LOAD, READ,
   input wire logic [7:0] START_ADDR, RDATA, input wire logic IN_RANGE);
   logic [7:0] p;
   wire rd = READ && !LOAD;
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) p <= 8'h00;
      else if (LOAD) p <= START_ADDR;
      else if (READ) p <= p + 8'h01;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   // ==========================
   // Contents and read path
   a_dual_out: assert property (rd && p == 8'h0C |=> RDATA == 8'h08) else $error("0C");
   a_dual_io: assert property (rd && p == 8'h0E |=> RDATA == 8'h88) else $error("0E");
   a_dual_out_op: assert property (rd && p == 8'h0D |=> RDATA == 8'h3B) else $error("0D");
   a_dual_io_op: assert property (rd && p == 8'h0F |=> RDATA == 8'hBB) else $error("0F");
   a_qpi_flag: assert property (rd && p == 8'h10 |=> RDATA == 8'hFE) else $error("10");
   a_no_dual_all: assert property (rd && p == 8'h10 |=> !RDATA[0]) else $error("b0");
   a_fill_ones: assert property (rd && p > 8'h10 && p < 8'h1A |=> RDATA == 8'hFF) else $error("FF");
   a_qpi_mode: assert property (rd && p == 8'h1A |=> RDATA == 8'h48) else $error("1A");
   a_qpi_op: assert property (rd && p == 8'h1B |=> RDATA == 8'hEB) else $error("1B");
   a_data_holds: assert property (!rd |=> $stable(RDATA)) else $error("hold");
   a_range_seq: assert property (rd |=> IN_RANGE == ($past(p) > 8'h0B && $past(p) < 8'h1C)) else $error("rng");
   c_walk: cover property (rd && p == 8'h1B);
   c_refuse: cover property (LOAD && READ);
   c_wrap: cover property (rd && p == 8'hFF);
endmodule

// file: verification/sfdpbp_host.sv
/* Host model: loads a start address, then reads back to back.
   Assumes CLK from the bench; drives on the falling edge. */
`timescale 1ns/1ps
module sfdpbp_host(input wire logic CLK, output logic LOAD = 0, output logic READ = 0,
   output logic [7:0] START_ADDR = 8'h00);
   task rd(input logic [7:0] a, input int n, input logic r);
      @(negedge CLK) begin LOAD = 1; START_ADDR = a; READ = r; end
      repeat (n) begin @(negedge CLK); LOAD = 0; READ = 1; START_ADDR = ~a; end
      @(negedge CLK) READ = 0;
   endtask
endmodule

// file: verification/tb.sv
/* Self-checking bench for the ROM slice.
   Assumes the design, host model and checker. */
`timescale 1ns/1ps
module tb;
   import sfdpbp_pkg::*;
   logic CLK = 0, NRST = 0, LOAD, READ, IN_RANGE, v = 0, r = 0;
   logic [7:0] START_ADDR, RDATA, q = 8'h00, e = 8'h00, la = 8'h00;
   int fail_count = 0, tests_run = 0, seed = 32'h6310, i;
   sfdpbp_host u_host(.CLK(CLK), .LOAD(LOAD), .READ(READ), .START_ADDR(START_ADDR));
   sfdpbp_rom u_dut(.CLK(CLK), .NRST(NRST), .LOAD(LOAD), .START_ADDR(START_ADDR),
      .READ(READ), .RDATA(RDATA), .IN_RANGE(IN_RANGE));
   function logic [7:0] ex(logic [7:0] a);
      case (a)
         8'h0C: ex = 8'h08; 8'h0D: ex = 8'h3B; 8'h0E: ex = 8'h88; 8'h0F: ex = 8'hBB;
         8'h10: ex = 8'hFE; 8'h1A: ex = 8'h48; 8'h1B: ex = 8'hEB; default: ex = 8'hFF;
      endcase
   endfunction
   task chk(logic [7:0] s, logic [7:0] x);
      tests_run++;
      if (s !== x) begin fail_count++; $display("ERROR %0t %h %h", $time, s, x); end
   endtask
   task stop_test;
      if (fail_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ==========================
   // Reference pointer and check
   always @(posedge CLK) begin
      v <= READ && !LOAD;
      if (LOAD) q <= START_ADDR;
      else if (READ) begin e <= ex(q); r <= (q > 8'h0B && q < 8'h1C); la <= q; q <= q + 8'h01; end
   end
   always @(negedge CLK) if (v && NRST) begin
      chk(RDATA, e);
      chk({7'h00, IN_RANGE}, {7'h00, r});
      if (la == 8'h0C || la == 8'h0E || la == 8'h1A) chk(RDATA & 8'h1F, 8'h08);
   end
   initial forever #25 CLK = ~CLK;
   initial begin #100000; fail_count++; stop_test; end
   initial begin
      repeat (4) @(negedge CLK);
      chk(RDATA, 8'h00);
      chk({7'h00, IN_RANGE}, 8'h00);
      NRST = 1;
      u_host.rd(8'h0C, 16, 1);
      u_host.rd(8'hFF, 3, 0);
      @(negedge CLK) NRST = 0;
      @(negedge CLK) NRST = 1;
      for (i = 0; i < 40; i++) u_host.rd(8'($random(seed)) & 8'h1F, ($random(seed) & 7) + 1, 1'($random(seed)));
      stop_test;
   end
endmodule
bind sfdpbp_rom sfdpbp_chk u_chk(.CLK(CLK), .NRST(NRST), .LOAD(LOAD), .READ(READ),
   .START_ADDR(START_ADDR), .RDATA(RDATA), .IN_RANGE(IN_RANGE));
